/* hdl/pfm_core.sv */
/*
  Program sequencer and memory-map logic of a small 8-bit controller core:
  program counter with bank and page rules, vectored single-level interrupts,
  eight-level return stack, working-register mapping, event counter and the
  serial/reset pin steering.
  Assumes an instruction decoder that presents one decoded operation per
  accepted strobe, a ROM addressed by PC, and inputs synchronous to CLK.
*/
`timescale 1ns/100ps
`include "pfm_defines.svh"

module pfm_core #(
  parameter int PC_W = 12,
  parameter int SP_W = 3,
  parameter int TMR_W = 8
)
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic POR_REQ,
  input wire logic OP_STB,
  input wire logic [3:0] OP_KIND,
  input wire logic [PC_W-1:0] OP_ARG,
  input wire logic OP_TWO_CYCLE,
  input wire logic [2:0] PSW_SAVE,
  input wire logic [2:0] REG_IDX,
  input wire logic [7:0] PTR_ADDR,
  input wire logic EXT_IRQ_TEST_ZERO_PIN,
  input wire logic COUNT_TEST_INPUT_PIN,
  input wire logic [2:0] IRQ_EN,
  input wire logic SER_IRQ,
  input wire logic SER_MODE,
  input wire logic SER_DATA_OUT,
  input wire logic SER_DATA_DRV,
  input wire logic SER_CLK_OUT,
  input wire logic SER_CLK_DRV,
  input wire logic [3:0] PORT2_LATCH,
  input wire logic SERIAL_DATA_PORT_LINE_I,
  input wire logic SCLK_I,
  output logic [PC_W-1:0] PC,
  output logic ROM_EN,
  output logic OP_ACK,
  output logic BUSY,
  output logic IN_SERVICE,
  output logic [SP_W-1:0] SP,
  output logic STK_WR,
  output logic STK_RD,
  output logic [7:0] STK_RAM_ADDR,
  output logic [15:0] STK_WR_DATA,
  output logic [2:0] PSW_RESTORE,
  output logic PSW_RESTORE_STB,
  output logic [7:0] REG_RAM_ADDR,
  output logic PTR_OK,
  output logic [TMR_W-1:0] TIMER_COUNT,
  output logic [3:0] PORT2_O,
  output logic [3:0] PORT2_OE,
  output logic SCLK_O,
  output logic SCLK_OE,
  output logic SER_DATA_IN,
  output logic SER_CLK_IN,
  output logic RESET_PIN_O,
  output logic RESET_PIN_OE
);

  localparam int DEPTH = 1 << SP_W;

  pfm_pkg::pfm_op_t op;
  logic op_go;
  logic irq_go;
  logic [2:0] pend_r;
  logic [2:0] pend_set, pend_clr;
  logic [2:0] irq_req;
  logic [PC_W-1:0] vec;
  logic ext_prev_r, t1_prev_r;
  logic ext_edge, t1_edge;
  logic cnt_en_r;
  logic tmr_ovf;
  logic prog_bank_r, wreg_bank_r;
  logic cond_hit;
  logic push, pop;
  logic [PC_W-1:0] pc_inc, pc_nxt;
  logic [SP_W-1:0] sp_dec;
  logic [14:0] stk_mem_r [0:DEPTH-1];
  logic [14:0] top_entry;

  assign op = pfm_pkg::pfm_op_t'(OP_KIND);

  // Inputs are synchronous, one flop is enough for edge detection
  assign ext_edge = EXT_IRQ_TEST_ZERO_PIN & ~ext_prev_r;
  assign t1_edge = COUNT_TEST_INPUT_PIN & ~t1_prev_r;
  assign tmr_ovf = cnt_en_r & t1_edge & (TIMER_COUNT == `PFM_TMR_MAX);

  assign irq_req = pend_r & IRQ_EN;
  // Service holds off further takes until the status-restoring return
  assign irq_go = ~SYS_RST & ~BUSY & ~IN_SERVICE & (|irq_req);
  // A request presented in the same cycle as an interrupt take is dropped
  assign op_go = OP_STB & ~BUSY & ~irq_go;

  assign push = irq_go | (op_go & (op == pfm_pkg::PFM_OP_CALL));
  assign pop = op_go & ((op == pfm_pkg::PFM_OP_PLAIN_RET) | (op == pfm_pkg::PFM_OP_STATUS_RET));
  assign sp_dec = SP - {{(SP_W-1){1'b0}}, 1'b1};
  assign top_entry = stk_mem_r[sp_dec];
  // Increment stays inside the bank; only jumps, interrupt takes and returns may change bank
  assign pc_inc = {PC[`PFM_BANK_BIT], PC[`PFM_BANK_BIT-1:0] + 11'h001};

  always_comb
  begin
    pend_set = 3'h0;
    pend_set[`PFM_SRC_EXT] = ext_edge;
    pend_set[`PFM_SRC_SER] = SER_IRQ;
    pend_set[`PFM_SRC_TMR] = tmr_ovf;
    pend_clr = 3'h0;
    vec = `PFM_VEC_RESET;
    // Single level: fixed order only breaks ties
    if (irq_req[`PFM_SRC_EXT])
    begin
      vec = `PFM_VEC_EXT;
      pend_clr[`PFM_SRC_EXT] = irq_go;
    end
    else if (irq_req[`PFM_SRC_SER])
    begin
      vec = `PFM_VEC_SER;
      pend_clr[`PFM_SRC_SER] = irq_go;
    end
    else if (irq_req[`PFM_SRC_TMR])
    begin
      vec = `PFM_VEC_TMR;
      pend_clr[`PFM_SRC_TMR] = irq_go;
    end
  end

  always_comb
  begin
    cond_hit = 1'b0;
    unique case (op)
      pfm_pkg::PFM_OP_BR_T0_HIGH: cond_hit = EXT_IRQ_TEST_ZERO_PIN;
      pfm_pkg::PFM_OP_BR_T0_LOW: cond_hit = ~EXT_IRQ_TEST_ZERO_PIN;
      pfm_pkg::PFM_OP_BR_T1_HIGH: cond_hit = COUNT_TEST_INPUT_PIN;
      pfm_pkg::PFM_OP_BR_T1_LOW: cond_hit = ~COUNT_TEST_INPUT_PIN;
      default: cond_hit = 1'b0;
    endcase
  end

  always_comb
  begin
    pc_nxt = PC;
    if (irq_go)
      pc_nxt = vec;
    else if (op_go)
    begin
      unique case (op)
        pfm_pkg::PFM_OP_JMP: pc_nxt = {prog_bank_r, OP_ARG[`PFM_BANK_BIT-1:0]};
        pfm_pkg::PFM_OP_BR_T0_HIGH,
        pfm_pkg::PFM_OP_BR_T0_LOW,
        pfm_pkg::PFM_OP_BR_T1_HIGH,
        pfm_pkg::PFM_OP_BR_T1_LOW:
          pc_nxt = cond_hit ? {PC[`PFM_PAGE_HI:`PFM_PAGE_LO], OP_ARG[`PFM_PAGE_LO-1:0]} : pc_inc;
        pfm_pkg::PFM_OP_CALL: pc_nxt = {PC[`PFM_BANK_BIT], OP_ARG[`PFM_BANK_BIT-1:0]};
        pfm_pkg::PFM_OP_PLAIN_RET,
        pfm_pkg::PFM_OP_STATUS_RET: pc_nxt = top_entry[PC_W-1:0];
        default: pc_nxt = pc_inc;
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      PC <= `PFM_VEC_RESET;
      ROM_EN <= 1'b1;
    end
    else
    begin
      PC <= pc_nxt;
      ROM_EN <= pc_nxt < `PFM_ROM_TOP;
    end
  end

  // Forced interrupt call and two-cycle instructions both hold one more cycle
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      BUSY <= 1'b0;
      OP_ACK <= 1'b0;
    end
    else
    begin
      BUSY <= irq_go | (op_go & OP_TWO_CYCLE);
      OP_ACK <= op_go;
    end
  end

  // Set beats clear when an event lands on the take cycle
  always_ff @(posedge CLK)
  begin
    // Pins tracked through reset so a level held high gives no edge
    ext_prev_r <= EXT_IRQ_TEST_ZERO_PIN;
    t1_prev_r <= COUNT_TEST_INPUT_PIN;
    if (SYS_RST)
    begin
      pend_r <= 3'h0;
      IN_SERVICE <= 1'b0;
    end
    else
    begin
      pend_r <= (pend_r & ~pend_clr) | pend_set;
      if (irq_go)
        IN_SERVICE <= 1'b1;
      else if (op_go && op == pfm_pkg::PFM_OP_STATUS_RET)
        IN_SERVICE <= 1'b0;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      prog_bank_r <= 1'b0;
      wreg_bank_r <= 1'b0;
    end
    else if (op_go)
    begin
      if (op == pfm_pkg::PFM_OP_PROG_BANK0 || op == pfm_pkg::PFM_OP_PROG_BANK1)
        prog_bank_r <= (op == pfm_pkg::PFM_OP_PROG_BANK1);
      if (op == pfm_pkg::PFM_OP_WREG_BANK0 || op == pfm_pkg::PFM_OP_WREG_BANK1)
        wreg_bank_r <= (op == pfm_pkg::PFM_OP_WREG_BANK1);
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      cnt_en_r <= 1'b0;
      TIMER_COUNT <= '0;
    end
    else
    begin
      if (op_go && op == pfm_pkg::PFM_OP_START_COUNT)
        cnt_en_r <= 1'b1;
      else if (op_go && op == pfm_pkg::PFM_OP_STOP_COUNT)
        cnt_en_r <= 1'b0;
      if (cnt_en_r && t1_edge)
        TIMER_COUNT <= TIMER_COUNT + 8'h01;
    end
  end

  // Stack storage mirrors the data-memory pair written through STK_*
  always_ff @(posedge CLK)
  begin
    if (push)
      stk_mem_r[SP] <= {PSW_SAVE, irq_go ? PC : pc_inc};
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      SP <= '0;
      STK_WR <= 1'b0;
      STK_RD <= 1'b0;
      STK_RAM_ADDR <= `PFM_STK_BASE;
      STK_WR_DATA <= 16'h0000;
      PSW_RESTORE <= 3'h0;
      PSW_RESTORE_STB <= 1'b0;
    end
    else
    begin
      STK_WR <= push;
      STK_RD <= pop;
      PSW_RESTORE_STB <= pop & (op == pfm_pkg::PFM_OP_STATUS_RET);
      if (push)
      begin
        SP <= SP + 3'h1;
        STK_RAM_ADDR <= `PFM_STK_BASE + {4'h0, SP, 1'b0};
        STK_WR_DATA <= {PSW_SAVE, 1'b0, irq_go ? PC : pc_inc};
      end
      else if (pop)
      begin
        SP <= sp_dec;
        STK_RAM_ADDR <= `PFM_STK_BASE + {4'h0, sp_dec, 1'b0};
        if (op == pfm_pkg::PFM_OP_STATUS_RET)
          PSW_RESTORE <= top_entry[14:12];
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      REG_RAM_ADDR <= `PFM_WREG_BANK0_BASE;
      PTR_OK <= 1'b0;
    end
    else
    begin
      // Two banks of eight give the sixteen direct locations
      REG_RAM_ADDR <= (wreg_bank_r ? `PFM_WREG_BANK1_BASE : `PFM_WREG_BANK0_BASE) + {5'h00, REG_IDX};
      PTR_OK <= PTR_ADDR < `PFM_RAM_TOP;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      PORT2_O <= 4'hF;
      PORT2_OE <= 4'h0;
      SCLK_O <= 1'b0;
      SCLK_OE <= 1'b0;
      SER_DATA_IN <= 1'b0;
      SER_CLK_IN <= 1'b0;
    end
    else
    begin
      PORT2_O <= {SER_MODE ? SER_DATA_OUT : PORT2_LATCH[3], PORT2_LATCH[2:0]};
      PORT2_OE <= {SER_MODE ? SER_DATA_DRV : 1'b1, 3'h7};
      SCLK_O <= SER_MODE & SER_CLK_OUT;
      SCLK_OE <= SER_MODE & SER_CLK_DRV;
      SER_DATA_IN <= SERIAL_DATA_PORT_LINE_I;
      SER_CLK_IN <= SCLK_I;
    end
  end

  // Not reset: the power-on request must still reach the pin while reset is held
  always_ff @(posedge CLK)
  begin
    RESET_PIN_O <= POR_REQ;
    RESET_PIN_OE <= POR_REQ;
  end

  default clocking cb @(posedge CLK);
  endclocking

  a_reset_pc_zero: assert property (SYS_RST |=> (PC == `PFM_VEC_RESET) && (SP == 3'h0))
    else $error("reset did not leave PC and SP at zero");
  a_ext_vector: assert property (disable iff (SYS_RST) (irq_go && irq_req[0]) |=> PC == `PFM_VEC_EXT)
    else $error("external vector wrong");
  a_ser_vector: assert property (disable iff (SYS_RST) (irq_go && irq_req == 3'h2) |=> PC == `PFM_VEC_SER)
    else $error("serial vector wrong");
  a_tmr_vector: assert property (disable iff (SYS_RST) (irq_go && irq_req == 3'h4) |=> PC == `PFM_VEC_TMR)
    else $error("timer vector wrong");
  a_no_nesting: assert property (disable iff (SYS_RST) irq_go |=> IN_SERVICE ##0 !irq_go)
    else $error("interrupt nested");
  a_jump_bank: assert property (disable iff (SYS_RST)
    (op_go && op == pfm_pkg::PFM_OP_JMP) |=> PC[`PFM_BANK_BIT] == $past(prog_bank_r))
    else $error("jump ignored selected bank");
  a_branch_page: assert property (disable iff (SYS_RST)
    (op_go && cond_hit) |=> PC == {$past(PC[`PFM_PAGE_HI:`PFM_PAGE_LO]), $past(OP_ARG[`PFM_PAGE_LO-1:0])})
    else $error("branch left its page");
  a_seq_keeps_bank: assert property (disable iff (SYS_RST)
    (op_go && op == pfm_pkg::PFM_OP_SEQ) |=> PC[`PFM_BANK_BIT] == $past(PC[`PFM_BANK_BIT]))
    else $error("sequential step crossed bank");
  a_push_advance: assert property (disable iff (SYS_RST) push |=> STK_WR && (SP - $past(SP)) == 3'h1)
    else $error("push did not advance stack pointer");
  a_plain_ret: assert property (disable iff (SYS_RST)
    (op_go && op == pfm_pkg::PFM_OP_PLAIN_RET) |=> ($past(SP) - SP) == 3'h1 && !PSW_RESTORE_STB)
    else $error("plain return wrong");
  a_two_cycle: assert property (disable iff (SYS_RST) (op_go && OP_TWO_CYCLE) |=> BUSY ##1 !BUSY)
    else $error("two-cycle hold wrong");
  a_wreg_map: assert property (disable iff (SYS_RST)
    ##1 !$past(SYS_RST) |->
    REG_RAM_ADDR == ($past(wreg_bank_r) ? `PFM_WREG_BANK1_BASE : `PFM_WREG_BANK0_BASE) + $past(REG_IDX))
    else $error("working register address wrong");

  c_ext_taken: cover property (disable iff (SYS_RST) irq_go && irq_req[0]);
  c_call_return: cover property (disable iff (SYS_RST) push ##[1:20] PSW_RESTORE_STB);
  c_timer_wrap: cover property (disable iff (SYS_RST) tmr_ovf);
  c_bank_jump: cover property (disable iff (SYS_RST) op_go && op == pfm_pkg::PFM_OP_JMP && prog_bank_r);

endmodule

/* hdl/pfm_defines.svh */
/*
  Constants of the program-flow and memory-map sequencer: vectors, memory
  sizes, data-memory bases and bank and page bit positions.
  Assumes inclusion by bare name from the sequencer and its package users.
*/
// Behaviour
// - Program store is 3072 bytes; program counter reaches every location.
// - After reset the first fetch is from address 0.
// - Taken external interrupt starts at address 3.
// - Taken serial interrupt starts at address 5.
// - Taken timer interrupt starts at address 7.
// - Three vectored sources, one priority level, no nesting.
// - Program space is 2K banks chosen by the bank-select operation.
// - Conditional branches stay inside the current 256-byte page.
// - Only an unconditional jump after bank select, an interrupt take or a return crosses banks.
// - Calls reach any page of the current bank; both returns restore the stacked address.
// - Data memory is 224 bytes, all reachable through pointer registers.
// - At most 16 locations are directly register addressed.
// - Eight-level return stack in data memory, three-bit pointer.
// - Interrupt/test pin fires on rising edge; level testable by branches.
// - Count test input is branch testable and clocks timer after start.
// - High reset level initialises; power-on circuit may drive reset pin.
// - Serial mode uses port line 3 and clock pin, both bidirectional.
// - Every instruction takes one or two machine cycles.
// - Reset clears stack pointer; push stores PC and three status bits.
// - Stack pointer wraps both ways, overwriting the deepest entry.
// - Both returns pop; only status-restoring return writes status back.
// - Working registers at 0-7 for bank zero, 24-31 for bank one.
`ifndef PFM_DEFINES_SVH
`define PFM_DEFINES_SVH

`define PFM_VEC_RESET 12'h000
`define PFM_VEC_EXT 12'h003
`define PFM_VEC_SER 12'h005
`define PFM_VEC_TMR 12'h007
`define PFM_ROM_TOP 12'hC00
`define PFM_RAM_TOP 8'hE0
`define PFM_STK_BASE 8'h08
`define PFM_WREG_BANK0_BASE 8'h00
`define PFM_WREG_BANK1_BASE 8'h18
`define PFM_BANK_BIT 11
`define PFM_PAGE_HI 11
`define PFM_PAGE_LO 8
`define PFM_SRC_EXT 0
`define PFM_SRC_SER 1
`define PFM_SRC_TMR 2
`define PFM_TMR_MAX 8'hFF

`endif

/* hdl/pfm_pkg.sv */
/*
  Types of the program-flow sequencer: the decoded operation codes.
  Assumes the decoder outside presents one of these codes per instruction.
*/
package pfm_pkg;
  typedef enum logic [3:0] {
    PFM_OP_SEQ = 4'h0,
    PFM_OP_JMP = 4'h1,
    PFM_OP_BR_T0_HIGH = 4'h2,
    PFM_OP_BR_T0_LOW = 4'h3,
    PFM_OP_BR_T1_HIGH = 4'h4,
    PFM_OP_BR_T1_LOW = 4'h5,
    PFM_OP_CALL = 4'h6,
    PFM_OP_PLAIN_RET = 4'h7,
    PFM_OP_STATUS_RET = 4'h8,
    PFM_OP_PROG_BANK0 = 4'h9,
    PFM_OP_PROG_BANK1 = 4'hA,
    PFM_OP_WREG_BANK0 = 4'hB,
    PFM_OP_WREG_BANK1 = 4'hC,
    PFM_OP_START_COUNT = 4'hD,
    PFM_OP_STOP_COUNT = 4'hE
  } pfm_op_t;
endpackage

/* tb/pfm_far_end.sv */
/*
  Far-side model: program ROM fetch monitor and external interrupt source.
  Assumes the bench raises ext_req and picks the lag in cycles before the edge.
*/
`timescale 1ns/100ps
module pfm_far_end (
  input wire logic clk,
  input wire logic [11:0] pc,
  input wire logic rom_en,
  input wire logic ext_req,
  input wire logic [1:0] lag,
  output logic ext_pin,
  output logic fetch_bad
);
  logic [1:0] wait_r = 2'b00;

  // Source is idle low, so every request gives a fresh rising edge
  always @(posedge clk)
  begin
    if (!ext_req)
    begin
      wait_r <= 2'b00;
      ext_pin <= 1'b0;
    end
    else if (wait_r >= lag)
      ext_pin <= 1'b1;
    else
      wait_r <= wait_r + 2'h1;
  end

  // Fetch beyond the populated store must not be enabled
  always @(posedge clk)
    fetch_bad <= rom_en && (pc >= 12'hC00);
endmodule

/* tb/tb.sv */
/*
  Self-checking bench of the sequencer with random and corner stimulus.
  Assumes pfm_core with default widths and the far-side model beside it.
*/
`timescale 1ns/100ps
module tb;
  logic clk = 0, sys_rst = 1, por_req = 0, por_old = 0, por_on = 0, live = 0, bank = 0, rst_old = 1;
  logic sclk_o, sclk_oe, sdi, sci;
  logic op_stb = 0, tc = 0, ext_req = 0, cnt_pin = 0, ser_irq = 0, t0, t1;
  logic rom_en, op_ack, busy, in_svc, stk_wr, stk_rd, psw_stb, ptr_ok, rst_o, rst_oe, ext_pin, fetch_bad;
  logic [1:0] lag = 0;
  logic [2:0] program_status_word = 0, reg_idx = 0, irq_en = 0, sp, sp_m, psw_rst, sk_ps [8];
  logic [3:0] op_kind = 0, k, p2o, p2oe;
  logic [7:0] ptr = 0, stk_addr, reg_addr, tmr;
  logic [10:0] sv = 0, sv_old = 0;
  logic [11:0] op_arg = 0, pc, pc0, exp, a, sk_pc [8];
  logic [15:0] stk_data;
  logic [31:0] seed = 32'h0C658A0D, r, rw, pr = 0;
  int failures = 0, n_tests = 0, i;

  always #2 clk = ~clk;

  pfm_core u_dut (.CLK(clk), .SYS_RST(sys_rst), .POR_REQ(por_req), .OP_STB(op_stb), .OP_KIND(op_kind),
    .OP_ARG(op_arg), .OP_TWO_CYCLE(tc), .PSW_SAVE(program_status_word), .REG_IDX(reg_idx), .PTR_ADDR(ptr),
    .EXT_IRQ_TEST_ZERO_PIN(ext_pin), .COUNT_TEST_INPUT_PIN(cnt_pin), .IRQ_EN(irq_en), .SER_IRQ(ser_irq),
    .SER_MODE(sv[0]), .SER_DATA_OUT(sv[1]), .SER_DATA_DRV(sv[2]), .SER_CLK_OUT(sv[3]), .SER_CLK_DRV(sv[4]),
    .PORT2_LATCH(sv[8:5]), .SERIAL_DATA_PORT_LINE_I(sv[9]), .SCLK_I(sv[10]), .PC(pc), .ROM_EN(rom_en),
    .OP_ACK(op_ack), .BUSY(busy), .IN_SERVICE(in_svc), .SP(sp), .STK_WR(stk_wr), .STK_RD(stk_rd),
    .STK_RAM_ADDR(stk_addr), .STK_WR_DATA(stk_data), .PSW_RESTORE(psw_rst), .PSW_RESTORE_STB(psw_stb),
    .REG_RAM_ADDR(reg_addr), .PTR_OK(ptr_ok), .TIMER_COUNT(tmr), .PORT2_O(p2o), .PORT2_OE(p2oe),
    .SCLK_O(sclk_o), .SCLK_OE(sclk_oe), .SER_DATA_IN(sdi), .SER_CLK_IN(sci), .RESET_PIN_O(rst_o),
    .RESET_PIN_OE(rst_oe));

  pfm_far_end u_far (.clk(clk), .pc(pc), .rom_en(rom_en), .ext_req(ext_req), .lag(lag),
    .ext_pin(ext_pin), .fetch_bad(fetch_bad));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Increment stays inside the current bank
  function automatic logic [11:0] inc(input logic [11:0] p);
    return {p[11], p[10:0] + 11'h001};
  endfunction

  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic end_sim();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    sp_m = 3'h0;
    bank = 1'b0;
    live = 1'b1;
    chk(pc === 12'h000, "reset pc");
    chk(sp === 3'h0 && stk_addr === 8'h08, "reset sp");
  endtask

  // Pins and status bits come from pr so callers can predict them
  task automatic op(input logic [3:0] kk, input logic [11:0] aa, input logic two);
    @(posedge clk);
    op_stb <= 1'b1;
    op_kind <= kk;
    op_arg <= aa;
    tc <= two;
    ext_req <= pr[0];
    cnt_pin <= pr[1];
    program_status_word <= pr[4:2];
    @(posedge clk);
    t0 = ext_pin;
    t1 = cnt_pin;
    op_stb <= 1'b0;
    #1;
    chk(op_ack === 1'b1, "no ack");
  endtask

  task automatic wait_svc(input logic [11:0] vec);
    for (int n = 0; n < 20 && in_svc !== 1'b1; n++)
      @(posedge clk);
    #1;
    chk(in_svc === 1'b1 && pc === vec, "vector");
  endtask

  always @(posedge clk)
  begin
    // Own draw word, so the main sequence keeps its r across edges
    rw = rnd();
    por_old <= por_req;
    rst_old <= sys_rst;
    sv_old <= sv;
    por_req <= por_on & rw[0];
    sv <= rw[11:1];
    #1;
    if (por_on)
      chk(rst_o === por_old && rst_oe === por_old, "reset pin");
    if (live)
      chk(fetch_bad === 1'b0, "fetch range");
    if (live && !rst_old)
    begin
      chk(p2o === {sv_old[0] ? sv_old[1] : sv_old[8], sv_old[7:5]}, "port data");
      chk(p2oe === {sv_old[0] ? sv_old[2] : 1'b1, 3'h7}, "port enable");
      chk(sclk_o === (sv_old[0] & sv_old[3]) && sclk_oe === (sv_old[0] & sv_old[4]), "serial clock pin");
      chk(sdi === sv_old[9] && sci === sv_old[10], "pin samples");
    end
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("mismatch at %0t: watchdog", $time);
    end_sim();
  end

  initial
  begin
    do_reset();
    for (i = 0; i < 60; i++)
    begin
      r = rnd();
      pr = rnd();
      k = (r[2:0] < 3'h6) ? {1'b0, r[2:0]} : (r[0] ? 4'h9 : 4'hA);
      a = r[23:12];
      pc0 = pc;
      op(k, a, 1'b0);
      case (k)
        pfm_pkg::PFM_OP_JMP: exp = {bank, a[10:0]};
        pfm_pkg::PFM_OP_BR_T0_HIGH: exp = t0 ? {pc0[11:8], a[7:0]} : inc(pc0);
        pfm_pkg::PFM_OP_BR_T0_LOW: exp = !t0 ? {pc0[11:8], a[7:0]} : inc(pc0);
        pfm_pkg::PFM_OP_BR_T1_HIGH: exp = t1 ? {pc0[11:8], a[7:0]} : inc(pc0);
        pfm_pkg::PFM_OP_BR_T1_LOW: exp = !t1 ? {pc0[11:8], a[7:0]} : inc(pc0);
        default: exp = inc(pc0);
      endcase
      bank = (k == 4'hA) ? 1'b1 : (k == 4'h9) ? 1'b0 : bank;
      chk(pc === exp, "flow");
      chk(rom_en === (pc < 12'hC00), "rom enable");
    end
    pr = 0;
    op(pfm_pkg::PFM_OP_SEQ, 12'h000, 1'b1);
    chk(busy === 1'b1, "two-cycle busy");
    @(posedge clk);
    #1;
    chk(busy === 1'b0, "busy stays");
    for (i = 0; i < 9; i++)
    begin
      pr = rnd();
      a = pr[31:20];
      pc0 = pc;
      op(pfm_pkg::PFM_OP_CALL, a, 1'b0);
      chk(pc === {pc0[11], a[10:0]} && stk_wr === 1'b1, "call");
      chk(stk_addr === 8'h08 + {4'h0, sp_m, 1'b0}, "stack slot");
      chk(stk_data === {pr[4:2], 1'b0, inc(pc0)}, "stack data");
      sk_pc[sp_m] = inc(pc0);
      sk_ps[sp_m] = pr[4:2];
      sp_m = sp_m + 3'h1;
      chk(sp === sp_m, "push wrap");
    end
    pr = 0;
    for (i = 0; i < 9; i++)
    begin
      k = i[0] ? pfm_pkg::PFM_OP_STATUS_RET : pfm_pkg::PFM_OP_PLAIN_RET;
      op(k, 12'h000, 1'b0);
      sp_m = sp_m - 3'h1;
      chk(pc === sk_pc[sp_m] && sp === sp_m && stk_rd === 1'b1, "return");
      chk(psw_stb === i[0] && (!i[0] || psw_rst === sk_ps[sp_m]), "status");
    end
    for (i = 0; i < 8; i++)
    begin
      r = rnd();
      op(r[0] ? pfm_pkg::PFM_OP_WREG_BANK1 : pfm_pkg::PFM_OP_WREG_BANK0, 12'h000, 1'b0);
      @(posedge clk);
      reg_idx <= r[3:1];
      ptr <= (i == 0) ? 8'hDF : (i == 1) ? 8'hE0 : r[15:8];
      repeat (2) @(posedge clk);
      #1;
      chk(reg_addr === (r[0] ? 8'h18 : 8'h00) + {5'h00, r[3:1]}, "work reg");
      chk(ptr_ok === (ptr < 8'hE0), "pointer");
    end
    por_on = 1'b1;
    repeat (40) @(posedge clk);
    #1;
    por_on = 1'b0;
    do_reset();
    @(posedge clk);
    irq_en <= 3'b001;
    lag <= 2'h3;
    ext_req <= 1'b1;
    wait_svc(12'h003);
    chk(sp === 3'h1 && stk_data[11:0] === 12'h000, "irq push");
    @(posedge clk);
    ext_req <= 1'b0;
    repeat (3) @(posedge clk);
    ext_req <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk(pc === 12'h003 && sp === 3'h1, "no nesting");
    op(pfm_pkg::PFM_OP_STATUS_RET, 12'h000, 1'b0);
    chk(pc === 12'h000 && in_svc === 1'b0, "irq return");
    wait_svc(12'h003);
    op(pfm_pkg::PFM_OP_STATUS_RET, 12'h000, 1'b0);
    @(posedge clk);
    irq_en <= 3'b010;
    ser_irq <= 1'b1;
    @(posedge clk);
    ser_irq <= 1'b0;
    wait_svc(12'h005);
    op(pfm_pkg::PFM_OP_STATUS_RET, 12'h000, 1'b0);
    @(posedge clk);
    irq_en <= 3'b100;
    op(pfm_pkg::PFM_OP_START_COUNT, 12'h000, 1'b0);
    for (i = 0; i < 255; i++)
    begin
      @(posedge clk);
      cnt_pin <= 1'b1;
      @(posedge clk);
      cnt_pin <= 1'b0;
    end
    repeat (2) @(posedge clk);
    #1;
    chk(tmr === 8'hFF && in_svc === 1'b0, "count");
    @(posedge clk);
    cnt_pin <= 1'b1;
    wait_svc(12'h007);
    end_sim();
  end
endmodule
